// ---- include/rtq_pkg.sv ----
// constants for the retirement tagging and queue latency monitor
// assumes a single core clock domain and an avalon-mm register master
package rtq_pkg;
    localparam int Q_DEPTH = 8;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 6;
    localparam int CAUSE_W = 6;
    // register byte offsets
    localparam logic [5:0] OFS_SAMPLE_EN = 6'h00;
    localparam logic [5:0] OFS_MATRIX_VERT = 6'h04;
    localparam logic [5:0] OFS_REPLAY_SEL = 6'h08;
    localparam logic [5:0] OFS_UOP_TYPE = 6'h0c;
    localparam logic [5:0] OFS_CONTROL = 6'h10;
    localparam logic [5:0] OFS_ALLOC_CNT = 6'h14;
    localparam logic [5:0] OFS_OCCUP_CNT = 6'h18;
    localparam logic [5:0] OFS_REPLAY_CNT = 6'h1c;
    localparam logic [5:0] OFS_FRONT_CNT = 6'h20;
    localparam logic [5:0] OFS_QUEUE_STAT = 6'h24;
    // sample enable register fields
    localparam int SE_L1_MISS = 0;
    localparam int SE_L2_MISS = 1;
    localparam int SE_DTLB = 2;
    localparam int SE_MOB = 9;
    localparam int SE_SPLIT = 10;
    localparam int SE_BR_A = 15;
    localparam int SE_BR_B = 16;
    localparam int SE_ARM_A = 24;
    localparam int SE_ARM_B = 25;
    // vertical matrix fields
    localparam int MV_LOAD = 0;
    localparam int MV_STORE = 1;
    localparam int MV_BRANCH = 4;
    // replay select register fields
    localparam int RS_MOB = 0;
    localparam int RS_SPLIT_LD = 1;
    localparam int RS_SPLIT_ST = 2;
    localparam int RS_NON_SPEC = 3;
    // micro-op type register fields
    localparam int UT_LOADS = 0;
    localparam int UT_STORES = 1;
    // control register fields
    localparam int CT_L3_PRESENT = 0;
    localparam int CT_COUNT_EN = 1;
    localparam int CT_CLEAR = 2;
    // replay cause vector positions
    localparam int RC_L1_MISS = 0;
    localparam int RC_L2_MISS = 1;
    localparam int RC_DTLB = 2;
    localparam int RC_MOB = 3;
    localparam int RC_SPLIT = 4;
    localparam int RC_MISPRED = 5;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {
        RTQ_LOAD_FULL = 2'b00,
        RTQ_LOAD_PART = 2'b01,
        RTQ_RFO = 2'b10,
        RTQ_WRITEBACK = 2'b11
    } rtq_req_kind_t;
endpackage

// ---- rtl/rtq_monitor.sv ----
// queue occupancy accounting and micro-op tagging for retirement counting
// assumes synchronous inputs on ref_clk_in and an avalon-mm master with waitrequest
module rtq_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [rtq_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // request side of the queue
    input wire logic req_valid_in,
    input wire rtq_pkg::rtq_req_kind_t req_kind_in,
    input wire logic req_l3_hit_in,
    output logic req_ready_out,
    // bus arbitration and completion
    input wire logic arb_slot_in,
    output logic bus_issue_valid_out,
    output logic [rtq_pkg::IDX_W-1:0] bus_issue_idx_out,
    output logic bus_issue_prefetch_out,
    input wire logic done_valid_in,
    input wire logic [rtq_pkg::IDX_W-1:0] done_idx_in,
    // early tagging
    input wire logic disp_valid_in,
    input wire logic disp_is_load_in,
    input wire logic disp_is_store_in,
    input wire logic disp_untaggable_in,
    input wire logic [rtq_pkg::CAUSE_W-1:0] disp_cause_in,
    output logic front_tag_out,
    output logic replay_tag_out,
    // retirement
    input wire logic retire_valid_in,
    input wire logic retire_bogus_in,
    input wire logic retire_front_tag_in,
    input wire logic retire_replay_tag_in,
    input wire logic fp_stack_fault_in
);
    import rtq_pkg::*;

    function automatic logic [IDX_W:0] first_set(input logic [Q_DEPTH-1:0] m);
        logic [IDX_W:0] r;
        r = {1'b0, {IDX_W{1'b0}}};
        for (int i = Q_DEPTH - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [IDX_W:0] pop_count(input logic [Q_DEPTH-1:0] m);
        logic [IDX_W:0] c;
        c = '0;
        for (int i = 0; i < Q_DEPTH; i++) begin
            c = c + {{IDX_W{1'b0}}, m[i]};
        end
        return c;
    endfunction

    logic [31:0] sample_enable_reg_ff;
    logic [31:0] tag_matrix_vertical_reg_ff;
    logic [31:0] replay_sel_ff;
    logic [31:0] uop_type_ff;
    logic [31:0] control_ff;
    logic [31:0] queue_alloc_count_ff;
    logic [31:0] queue_occupancy_count_ff;
    logic [31:0] replay_count_ff;
    logic [31:0] front_count_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [Q_DEPTH-1:0] valid_ff;
    logic [Q_DEPTH-1:0] issued_ff;
    logic [Q_DEPTH-1:0] prefetch_ff;
    logic [Q_DEPTH-1:0] local_ff;
    logic ready_ff;
    logic issue_v_ff;
    logic [IDX_W-1:0] issue_idx_ff;
    logic issue_pf_ff;
    logic front_tag_ff;
    logic replay_tag_ff;

    // register bus: one wait cycle, then the answer stands for the sampling edge
    wire bus_req = avs_read_in | avs_write_in;
    wire bus_take = bus_req & ~wait_ff;
    wire wr_take = avs_write_in & ~wait_ff;
    wire wr_sample_en = wr_take & (avs_address_in == OFS_SAMPLE_EN);
    wire wr_matrix = wr_take & (avs_address_in == OFS_MATRIX_VERT);
    wire wr_replay_sel = wr_take & (avs_address_in == OFS_REPLAY_SEL);
    wire wr_uop_type = wr_take & (avs_address_in == OFS_UOP_TYPE);
    wire wr_control = wr_take & (avs_address_in == OFS_CONTROL);
    wire clear_counts = wr_control & avs_writedata_in[CT_CLEAR];
    wire count_en = control_ff[CT_COUNT_EN];
    wire l3_present = control_ff[CT_L3_PRESENT];
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address_in)
            OFS_SAMPLE_EN: rd_mux = sample_enable_reg_ff;
            OFS_MATRIX_VERT: rd_mux = tag_matrix_vertical_reg_ff;
            OFS_REPLAY_SEL: rd_mux = replay_sel_ff;
            OFS_UOP_TYPE: rd_mux = uop_type_ff;
            OFS_CONTROL: rd_mux = control_ff;
            OFS_ALLOC_CNT: rd_mux = queue_alloc_count_ff;
            OFS_OCCUP_CNT: rd_mux = queue_occupancy_count_ff;
            OFS_REPLAY_CNT: rd_mux = replay_count_ff;
            OFS_FRONT_CNT: rd_mux = front_count_ff;
            OFS_QUEUE_STAT: rd_mux = {16'h0000, issued_ff, valid_ff};
            default: rd_mux = RESET_WORD;
        endcase
    end

    // queue allocation: a full-line load takes a demand entry plus its adjacent sector
    wire [IDX_W:0] free_a = first_set(~valid_ff);
    wire [Q_DEPTH-1:0] one_hot_a = Q_DEPTH'(1) << free_a[IDX_W-1:0];
    wire [IDX_W:0] free_b = first_set(~valid_ff & ~one_hot_a);
    wire [Q_DEPTH-1:0] one_hot_b = Q_DEPTH'(1) << free_b[IDX_W-1:0];
    wire req_take = req_valid_in & ready_ff;
    wire take_pair = req_take & (req_kind_in == RTQ_LOAD_FULL);
    // every writeback allocates; an l3 hit stays local and never goes to the bus
    wire wb_local = (req_kind_in == RTQ_WRITEBACK) & l3_present & req_l3_hit_in;
    wire [Q_DEPTH-1:0] alloc_mask = (req_take ? one_hot_a : '0) | (take_pair ? one_hot_b : '0);

    // arbitration: demand entries first, the sector prefetch only on an idle slot
    wire [Q_DEPTH-1:0] pend = valid_ff & ~issued_ff & ~local_ff;
    wire [IDX_W:0] pick_dem = first_set(pend & ~prefetch_ff);
    wire [IDX_W:0] pick_pf = first_set(pend & prefetch_ff);
    wire use_dem = pick_dem[IDX_W];
    wire issue_now = arb_slot_in & (use_dem | pick_pf[IDX_W]);
    wire [IDX_W-1:0] issue_idx = use_dem ? pick_dem[IDX_W-1:0] : pick_pf[IDX_W-1:0];
    wire [Q_DEPTH-1:0] issue_mask = issue_now ? (Q_DEPTH'(1) << issue_idx) : '0;

    // release only on whole-transaction completion, never on a first data chunk
    wire [Q_DEPTH-1:0] done_hot = Q_DEPTH'(1) << done_idx_in;
    wire [Q_DEPTH-1:0] free_mask = done_valid_in ? (done_hot & valid_ff & (issued_ff | local_ff))
        : '0;
    wire [Q_DEPTH-1:0] nxt_valid = (valid_ff & ~free_mask) | alloc_mask;
    wire [IDX_W:0] nxt_free = pop_count(~nxt_valid);
    wire [IDX_W:0] occupied = pop_count(valid_ff);

    // tagging at dispatch
    wire taggable = disp_valid_in & ~disp_untaggable_in;
    wire armed = sample_enable_reg_ff[SE_ARM_A] & sample_enable_reg_ff[SE_ARM_B];
    wire mv_ld = tag_matrix_vertical_reg_ff[MV_LOAD] & disp_is_load_in;
    wire mv_st = tag_matrix_vertical_reg_ff[MV_STORE] & disp_is_store_in;
    wire split_ok = (disp_is_load_in & replay_sel_ff[RS_SPLIT_LD])
        | (disp_is_store_in & replay_sel_ff[RS_SPLIT_ST]);
    wire mem_hit = (disp_cause_in[RC_L1_MISS] & sample_enable_reg_ff[SE_L1_MISS])
        | (disp_cause_in[RC_L2_MISS] & sample_enable_reg_ff[SE_L2_MISS])
        | (disp_cause_in[RC_DTLB] & sample_enable_reg_ff[SE_DTLB])
        | (disp_cause_in[RC_MOB] & sample_enable_reg_ff[SE_MOB] & replay_sel_ff[RS_MOB])
        | (disp_cause_in[RC_SPLIT] & sample_enable_reg_ff[SE_SPLIT] & split_ok);
    wire br_hit = disp_cause_in[RC_MISPRED] & sample_enable_reg_ff[SE_BR_A]
        & sample_enable_reg_ff[SE_BR_B] & tag_matrix_vertical_reg_ff[MV_BRANCH];
    wire nxt_replay_tag = taggable & armed & ((mem_hit & (mv_ld | mv_st)) | br_hit);
    wire nxt_front_tag = taggable & ((disp_is_load_in & uop_type_ff[UT_LOADS])
        | (disp_is_store_in & uop_type_ff[UT_STORES]));

    // retirement counting: tag, plus the programmed event for replay only, non-bogus only
    wire ret_ok = retire_valid_in & ~retire_bogus_in;
    wire replay_inc = ret_ok & retire_replay_tag_in & replay_sel_ff[RS_NON_SPEC];
    // an fp stack fault drops the tagged op; the count is known to run low then
    wire front_inc = ret_ok & retire_front_tag_in & ~fp_stack_fault_in;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wait_ff <= 1'b1;
            rdata_ff <= RESET_WORD;
            sample_enable_reg_ff <= RESET_WORD;
            tag_matrix_vertical_reg_ff <= RESET_WORD;
            replay_sel_ff <= RESET_WORD;
            uop_type_ff <= RESET_WORD;
            control_ff <= RESET_WORD;
        end else begin
            wait_ff <= ~(bus_req & wait_ff);
            if (bus_req & wait_ff) begin
                rdata_ff <= rd_mux;
            end
            if (wr_sample_en) begin
                sample_enable_reg_ff <= avs_writedata_in;
            end
            if (wr_matrix) begin
                tag_matrix_vertical_reg_ff <= avs_writedata_in;
            end
            if (wr_replay_sel) begin
                replay_sel_ff <= avs_writedata_in;
            end
            if (wr_uop_type) begin
                uop_type_ff <= avs_writedata_in;
            end
            if (wr_control) begin
                control_ff <= avs_writedata_in & 32'h0000_0003;
            end
        end
    end

    // counters; a clear on the same edge wins because it is a reset of the tally
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || clear_counts) begin
            queue_alloc_count_ff <= RESET_WORD;
            queue_occupancy_count_ff <= RESET_WORD;
            replay_count_ff <= RESET_WORD;
            front_count_ff <= RESET_WORD;
        end else if (count_en) begin
            queue_alloc_count_ff <= queue_alloc_count_ff + {31'h0, req_take};
            queue_occupancy_count_ff <= queue_occupancy_count_ff
                + {{(32 - IDX_W - 1){1'b0}}, occupied};
            replay_count_ff <= replay_count_ff + {31'h0, replay_inc};
            front_count_ff <= front_count_ff + {31'h0, front_inc};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            valid_ff <= '0;
            issued_ff <= '0;
            prefetch_ff <= '0;
            local_ff <= '0;
            ready_ff <= 1'b0;
            issue_v_ff <= 1'b0;
            issue_idx_ff <= '0;
            issue_pf_ff <= 1'b0;
        end else begin
            valid_ff <= nxt_valid;
            issued_ff <= (issued_ff & ~free_mask) | issue_mask;
            prefetch_ff <= (prefetch_ff & ~free_mask & ~alloc_mask)
                | (take_pair ? one_hot_b : '0);
            local_ff <= (local_ff & ~free_mask & ~alloc_mask)
                | ((req_take & wb_local) ? one_hot_a : '0);
            ready_ff <= nxt_free >= (IDX_W + 1)'(2);
            issue_v_ff <= issue_now;
            issue_idx_ff <= issue_idx;
            issue_pf_ff <= issue_now & ~use_dem;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            front_tag_ff <= 1'b0;
            replay_tag_ff <= 1'b0;
        end else begin
            front_tag_ff <= nxt_front_tag;
            replay_tag_ff <= nxt_replay_tag;
        end
    end

    assign avs_readdata_out = rdata_ff;
    assign avs_waitrequest_out = wait_ff;
    assign req_ready_out = ready_ff;
    assign bus_issue_valid_out = issue_v_ff;
    assign bus_issue_idx_out = issue_idx_ff;
    assign bus_issue_prefetch_out = issue_pf_ff;
    assign front_tag_out = front_tag_ff;
    assign replay_tag_out = replay_tag_ff;
endmodule // rtq_monitor

// ---- verif/rtq_monitor_sva.sv ----
// assertions on the ports of the queue latency and tagging monitor
// assumes one clock, synchronous active-low reset, bound to every rtq_monitor
module rtq_monitor_sva (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic arb_slot_in,
    input wire logic bus_issue_valid_out,
    input wire logic disp_valid_in,
    input wire logic disp_is_load_in,
    input wire logic disp_is_store_in,
    input wire logic disp_untaggable_in,
    input wire logic [5:0] disp_cause_in,
    input wire logic front_tag_out,
    input wire logic replay_tag_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_wait_answers: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("waitrequest did not drop for a request");
    a_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
        else $error("waitrequest low without a request");
    a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in > 6'h24 |-> avs_readdata_out == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_issue_cause: assert property (bus_issue_valid_out |-> $past(arb_slot_in))
        else $error("issue without an arbitration slot");
    a_untag_never: assert property (disp_valid_in && disp_untaggable_in
        |=> !front_tag_out && !replay_tag_out) else $error("untaggable op was tagged");
    a_tag_idle: assert property (!disp_valid_in |=> !front_tag_out && !replay_tag_out)
        else $error("tag raised without a dispatched op");
    a_front_mem: assert property (front_tag_out
        |-> $past(disp_is_load_in || disp_is_store_in)) else $error("front tag on non-memory op");
    a_replay_cause: assert property (replay_tag_out |-> $past(disp_cause_in) != 6'h00)
        else $error("replay tag with no replay cause");
endmodule // rtq_monitor_sva
bind rtq_monitor rtq_monitor_sva u_sva (.ref_clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .arb_slot_in, .bus_issue_valid_out,
    .disp_valid_in, .disp_is_load_in, .disp_is_store_in, .disp_untaggable_in, .disp_cause_in,
    .front_tag_out, .replay_tag_out);

// ---- verif/tb.sv ----
// self-checking bench for rtq_monitor with an integer model of the counters
// assumes an avalon-mm slave that holds waitrequest until it answers, queue depth 8
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rtq_pkg::*;
    logic ref_clk_in = 1'h0, rst_n_in = 1'h0;
    logic [5:0] avs_address_in = 6'h0;
    logic avs_read_in = 1'h0, avs_write_in = 1'h0, avs_waitrequest_out;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
    rtq_req_kind_t req_kind_in = RTQ_RFO;
    logic req_valid_in = 1'h0, req_l3_hit_in = 1'h0, req_ready_out, arb_slot_in = 1'h0;
    logic bus_issue_valid_out, bus_issue_prefetch_out, done_valid_in = 1'h0;
    logic [2:0] bus_issue_idx_out, done_idx_in = 3'h0, ia, ib, ic;
    logic disp_valid_in = 1'h0, disp_is_load_in = 1'h0, disp_is_store_in = 1'h0;
    logic disp_untaggable_in = 1'h0, front_tag_out, replay_tag_out;
    logic [5:0] disp_cause_in = 6'h0;
    logic retire_valid_in = 1'h0, retire_bogus_in = 1'h0, retire_front_tag_in = 1'h0;
    logic retire_replay_tag_in = 1'h0, fp_stack_fault_in = 1'h0, cnt_en = 1'h0;
    int n_errors = 0, num_checks = 0, seed = 22643, m_occ = 0, m_alloc = 0, m_valid = 0;
    int m_rep = 0, m_fe = 0;
    rtq_monitor dut (.ref_clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .req_valid_in, .req_kind_in,
        .req_l3_hit_in, .req_ready_out, .arb_slot_in, .bus_issue_valid_out, .bus_issue_idx_out,
        .bus_issue_prefetch_out, .done_valid_in, .done_idx_in, .disp_valid_in, .disp_is_load_in,
        .disp_is_store_in, .disp_untaggable_in, .disp_cause_in, .front_tag_out, .replay_tag_out,
        .retire_valid_in, .retire_bogus_in, .retire_front_tag_in, .retire_replay_tag_in,
        .fp_stack_fault_in);
    always #5 ref_clk_in = !ref_clk_in;
    // model samples pre-edge values, the same ones the design registers
    always @(posedge ref_clk_in) begin
        if (rst_n_in && cnt_en) begin
            m_occ += m_valid;
            m_rep += retire_valid_in && !retire_bogus_in && retire_replay_tag_in;
            m_fe += retire_valid_in && !retire_bogus_in && retire_front_tag_in && !fp_stack_fault_in;
        end
        if (req_valid_in && req_ready_out) begin
            m_valid += (req_kind_in == RTQ_LOAD_FULL) ? 2 : 1;
            m_alloc++;
        end
        if (done_valid_in) m_valid--;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        // values read right at the edge are the ones the slave saw there
        do begin
            @(posedge ref_clk_in);
        end while (avs_waitrequest_out !== 1'h0);
        q = avs_readdata_out;
        avs_read_in <= 1'h0;
        avs_write_in <= 1'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string nm);
        bus(1'h0, a, 32'h0);
        check(nm, exp, q);
    endtask
    task automatic req(input rtq_req_kind_t k, input logic hit);
        @(posedge ref_clk_in);
        req_valid_in <= 1'h1;
        req_kind_in <= k;
        req_l3_hit_in <= hit;
        @(posedge ref_clk_in);
        req_valid_in <= 1'h0;
    endtask
    task automatic arb(input logic pf, input logic vld, output logic [2:0] idx);
        logic seen;
        seen = 1'h0;
        idx = 3'h0;
        @(posedge ref_clk_in);
        arb_slot_in <= 1'h1;
        repeat (3) begin
            @(negedge ref_clk_in);
            if (bus_issue_valid_out === 1'h1) begin
                seen = 1'h1;
                idx = bus_issue_idx_out;
                check("issue_prefetch", pf, bus_issue_prefetch_out);
            end
            @(posedge ref_clk_in);
            arb_slot_in <= 1'h0;
        end
        check("issue_valid", vld, seen);
    endtask
    task automatic done(input logic [2:0] idx);
        @(posedge ref_clk_in);
        done_valid_in <= 1'h1;
        done_idx_in <= idx;
        @(posedge ref_clk_in);
        done_valid_in <= 1'h0;
    endtask
    task automatic disp(input logic ld, st, un, input logic [5:0] c, input logic ef, er);
        @(posedge ref_clk_in);
        disp_valid_in <= 1'h1;
        disp_is_load_in <= ld;
        disp_is_store_in <= st;
        disp_untaggable_in <= un;
        disp_cause_in <= c;
        @(posedge ref_clk_in);
        disp_valid_in <= 1'h0;
        @(negedge ref_clk_in);
        check("front_tag", ef, front_tag_out);
        check("replay_tag", er, replay_tag_out);
    endtask
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    initial begin
        logic [31:0] v;
        repeat (4) @(posedge ref_clk_in);
        rst_n_in <= 1'h1;
        for (int i = 0; i < 10; i++) rd(i * 4, RESET_WORD, "reset_value");
        wr_unmapped: bus(1'h1, 6'h3c, $random(seed));
        rd(6'h3c, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            bus(1'h1, i * 4, v);
            rd(i * 4, v, "config_reg");
        end
        bus(1'h1, OFS_CONTROL, 32'hffffffff);
        rd(OFS_CONTROL, 32'h3, "control_bits");
        $display("test registers done");
        bus(1'h1, OFS_CONTROL, 32'h7);
        m_occ = 0;
        m_alloc = 0;
        cnt_en = 1'h1;
        req(RTQ_RFO, 1'h0);
        req(RTQ_WRITEBACK, 1'h1);
        req(RTQ_LOAD_FULL, 1'h0);
        @(negedge ref_clk_in);
        check("req_ready", 1'h1, req_ready_out);
        rd(OFS_ALLOC_CNT, m_alloc, "alloc_count");
        bus(1'h0, OFS_QUEUE_STAT, 32'h0);
        check("valid_entries", 4, $countones(q[7:0]));
        arb(1'h0, 1'h1, ia);
        arb(1'h0, 1'h1, ib);
        arb(1'h1, 1'h1, ic);
        arb(1'h0, 1'h0, v[2:0]);
        repeat ($unsigned($random(seed)) % 20) @(posedge ref_clk_in);
        bus(1'h0, OFS_QUEUE_STAT, 32'h0);
        v = q[7:0] & ~q[15:8];
        check("issued_entries", 3, $countones(q[15:8]));
        done(ia);
        done(ib);
        bus(1'h0, OFS_QUEUE_STAT, 32'h0);
        check("held_entries", 2, $countones(q[7:0]));
        done(ic);
        for (int i = 0; i < 8; i++) if (v[i]) done(i[2:0]);
        rd(OFS_QUEUE_STAT, 32'h0, "queue_empty");
        rd(OFS_OCCUP_CNT, m_occ, "occupancy");
        $display("test queue done");
        bus(1'h1, OFS_SAMPLE_EN, 32'h03000001);
        bus(1'h1, OFS_MATRIX_VERT, 32'h1);
        bus(1'h1, OFS_UOP_TYPE, 32'h1);
        disp(1'h1, 1'h0, 1'h0, 6'h01, 1'h1, 1'h1);
        disp(1'h1, 1'h0, 1'h1, 6'h01, 1'h0, 1'h0);
        disp(1'h0, 1'h1, 1'h0, 6'h01, 1'h0, 1'h0);
        disp(1'h1, 1'h0, 1'h0, 6'h02, 1'h1, 1'h0);
        bus(1'h1, OFS_UOP_TYPE, 32'h2);
        disp(1'h0, 1'h1, 1'h0, 6'h00, 1'h1, 1'h0);
        bus(1'h1, OFS_REPLAY_SEL, 32'h2);
        bus(1'h1, OFS_SAMPLE_EN, 32'h03018400);
        bus(1'h1, OFS_MATRIX_VERT, 32'h11);
        disp(1'h1, 1'h0, 1'h0, 6'h10, 1'h0, 1'h1);
        disp(1'h0, 1'h0, 1'h0, 6'h20, 1'h0, 1'h1);
        disp(1'h0, 1'h1, 1'h0, 6'h10, 1'h1, 1'h0);
        $display("test tagging done");
        bus(1'h1, OFS_REPLAY_SEL, 32'h8);
        m_rep = 0;
        m_fe = 0;
        for (int i = 0; i < 24; i++) begin
            v = $random(seed);
            @(posedge ref_clk_in);
            retire_valid_in <= 1'h1;
            retire_bogus_in <= v[0];
            retire_front_tag_in <= v[1];
            retire_replay_tag_in <= v[2];
            fp_stack_fault_in <= v[3];
        end
        @(posedge ref_clk_in);
        retire_valid_in <= 1'h0;
        // let the model take the last retirement before its tally is read
        @(negedge ref_clk_in);
        rd(OFS_REPLAY_CNT, m_rep, "replay_count");
        rd(OFS_FRONT_CNT, m_fe, "front_count");
        bus(1'h1, OFS_CONTROL, 32'h7);
        rd(OFS_REPLAY_CNT, 32'h0, "cleared_count");
        $display("test retirement done");
        complete_run();
    end
endmodule // tb
